// File: hdl/hapc_cfg.svh
`ifndef HAPC_CFG_SVH
`define HAPC_CFG_SVH

// register word indexes (byte address = index * 4)
`define HAPC_REG_CTRL 4'h0
`define HAPC_REG_DESIG 4'h1
`define HAPC_REG_SRC0 4'h2
`define HAPC_REG_SRC1 4'h3
`define HAPC_REG_SRC2 4'h4
`define HAPC_REG_DST0 4'h5
`define HAPC_REG_DST1 4'h6
`define HAPC_REG_DST2 4'h7
`define HAPC_REG_STATUS 4'h8

// control and status bit positions
`define HAPC_CTRL_START 0
`define HAPC_CTRL_OP 1
`define HAPC_STAT_BUSY 0
`define HAPC_STAT_ERR 1

// reset values
`define HAPC_WORD_RST 16'h0000
`define HAPC_RDATA_RST 32'h0000_0000

// designator field limits
`define HAPC_PAR_NONE 4'h0
`define HAPC_PAR_EVEN 4'h1
`define HAPC_PAR_ODD 4'h2
`define HAPC_SBYTE_MAX 4'h1
`define HAPC_CNT_MAX 4'h3
`define HAPC_SDIG_MAX 4'h3

// character codes
`define HAPC_ASC_ZERO 7'h30
`define HAPC_ASC_NINE 7'h39
`define HAPC_ASC_A 7'h41
`define HAPC_ASC_F 7'h46
`define HAPC_ALPHA_OFS 7'h37
`define HAPC_DEC_MAX 4'h9

// conversion positions
`define HAPC_SLOT_W0_LO 3'h0
`define HAPC_SLOT_W0_HI 3'h1
`define HAPC_SLOT_LAST 3'h4
`define HAPC_DIG_0 2'h0

`endif

// File: hdl/hapc_pkg.sv
package hapc_pkg;

   typedef struct packed {
      logic [3:0] par;
      logic [3:0] sbyte;
      logic [3:0] cnt;
      logic [3:0] sdig;
   } hapc_desig_type;

   typedef enum logic [1:0] {
      HAPC_IDLE = 2'b00,
      HAPC_CHECK = 2'b01,
      HAPC_CONV = 2'b11
   } hapc_state_type;

   typedef enum logic {
      HAPC_OP_HEX_TO_TEXT = 1'b0,
      HAPC_OP_TEXT_TO_HEX = 1'b1
   } hapc_op_type;

endpackage : hapc_pkg

// File: hdl/hapc_top.sv
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "hapc_cfg.svh"
module hapc_top
   import hapc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic error_flag,
   output logic busy
);

   localparam int NWORDS = 3;

   hapc_state_type state, next_state;
   hapc_op_type op, next_op;
   hapc_desig_type desig, next_desig;
   logic [15:0] src [NWORDS];
   logic [15:0] next_src [NWORDS];
   logic [15:0] dst [NWORDS];
   logic [15:0] next_dst [NWORDS];
   logic [1:0] idx, next_idx;
   logic rd_ready, next_rd_ready;
   logic [31:0] next_readdata;
   logic next_error_flag;

   logic desig_bad;
   logic chk_err;
   logic wr_acc;
   logic [3:0] reg_idx;
   logic [2:0] cur_slot;
   logic [1:0] cur_dig;
   logic [7:0] cur_char;
   logic [7:0] cur_src_byte;

   // merge a bus write into a 16-bit register through its byte lanes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction : merge16

   function automatic logic [7:0] to_char(input logic [3:0] dig, input logic [3:0] par);
      logic [6:0] c;
      c = (dig <= `HAPC_DEC_MAX) ? `HAPC_ASC_ZERO + {3'b000, dig}
                                 : `HAPC_ALPHA_OFS + {3'b000, dig};
      unique case (par)
         `HAPC_PAR_EVEN: to_char = {^c, c};
         `HAPC_PAR_ODD: to_char = {~^c, c};
         default: to_char = {1'b0, c};
      endcase
   endfunction : to_char

   function automatic logic char_bad(input logic [7:0] b, input logic [3:0] par);
      logic [6:0] c;
      logic valid;
      logic par_err;
      c = b[6:0];
      valid = (c >= `HAPC_ASC_ZERO && c <= `HAPC_ASC_NINE)
           || (c >= `HAPC_ASC_A && c <= `HAPC_ASC_F);
      unique case (par)
         `HAPC_PAR_EVEN: par_err = ^b;
         `HAPC_PAR_ODD: par_err = ~^b;
         default: par_err = b[7];
      endcase
      char_bad = !valid || par_err;
   endfunction : char_bad

   function automatic logic [3:0] to_digit(input logic [7:0] b);
      logic [6:0] d;
      d = (b[6:0] <= `HAPC_ASC_NINE) ? b[6:0] - `HAPC_ASC_ZERO : b[6:0] - `HAPC_ALPHA_OFS;
      to_digit = d[3:0];
   endfunction : to_digit

   // byte slot 0 = lower byte of word 0, slot 1 = upper, slot 2 = lower of word 1, ...
   function automatic logic [7:0] src_byte(input logic [2:0] slot, input logic [15:0] w0,
                                           input logic [15:0] w1, input logic [15:0] w2);
      logic [15:0] w;
      unique case (slot[2:1])
         2'b00: w = w0;
         2'b01: w = w1;
         default: w = w2;
      endcase
      src_byte = slot[0] ? w[15:8] : w[7:0];
   endfunction : src_byte

   assign reg_idx = avs_address[5:2];
   assign busy = (state != HAPC_IDLE);
   // reads take two cycles so read data comes from a flop; writes stall while converting
   assign avs_waitrequest = (avs_read && !rd_ready) || (avs_write && busy);
   assign wr_acc = avs_write && !busy;

   always_comb begin
      desig_bad = (desig.par > `HAPC_PAR_ODD) || (desig.sbyte > `HAPC_SBYTE_MAX)
               || (desig.cnt > `HAPC_CNT_MAX) || (desig.sdig > `HAPC_SDIG_MAX);
      chk_err = desig_bad;
      if (op == HAPC_OP_TEXT_TO_HEX) begin
         for (int i = 0; i < 4; i++) begin
            if (i[1:0] <= desig.cnt[1:0] &&
                char_bad(src_byte({2'b00, desig.sbyte[0]} + 3'(i), src[0], src[1], src[2]),
                         desig.par)) begin
               chk_err = 1'b1;
            end
         end
      end
   end

   // current step of the conversion
   always_comb begin
      cur_slot = {2'b00, desig.sbyte[0]} + {1'b0, idx};
      cur_dig = desig.sdig[1:0] + idx;
      cur_char = to_char(src[0][{cur_dig, 2'b00} +: 4], desig.par);
      cur_src_byte = src_byte(cur_slot, src[0], src[1], src[2]);
   end

   always_comb begin
      next_state = state;
      next_op = op;
      next_desig = desig;
      next_src = src;
      next_dst = dst;
      next_idx = idx;
      next_error_flag = error_flag;
      next_rd_ready = avs_read && !rd_ready;
      next_readdata = avs_readdata;

      if (avs_read && !rd_ready) begin
         next_readdata = `HAPC_RDATA_RST;
         unique case (reg_idx)
            `HAPC_REG_CTRL: next_readdata[`HAPC_CTRL_OP] = op;
            `HAPC_REG_DESIG: next_readdata[15:0] = desig;
            `HAPC_REG_SRC0: next_readdata[15:0] = src[0];
            `HAPC_REG_SRC1: next_readdata[15:0] = src[1];
            `HAPC_REG_SRC2: next_readdata[15:0] = src[2];
            `HAPC_REG_DST0: next_readdata[15:0] = dst[0];
            `HAPC_REG_DST1: next_readdata[15:0] = dst[1];
            `HAPC_REG_DST2: next_readdata[15:0] = dst[2];
            `HAPC_REG_STATUS: begin
               next_readdata[`HAPC_STAT_BUSY] = busy;
               next_readdata[`HAPC_STAT_ERR] = error_flag;
            end
            default: next_readdata = `HAPC_RDATA_RST;
         endcase
      end

      if (wr_acc) begin
         unique case (reg_idx)
            `HAPC_REG_CTRL: begin
               if (avs_byteenable[0]) begin
                  next_op = hapc_op_type'(avs_writedata[`HAPC_CTRL_OP]);
                  if (avs_writedata[`HAPC_CTRL_START]) begin
                     next_state = HAPC_CHECK;
                     next_idx = 2'b00;
                  end
               end
            end
            `HAPC_REG_DESIG: next_desig = merge16(desig, avs_writedata, avs_byteenable);
            `HAPC_REG_SRC0: next_src[0] = merge16(src[0], avs_writedata, avs_byteenable);
            `HAPC_REG_SRC1: next_src[1] = merge16(src[1], avs_writedata, avs_byteenable);
            `HAPC_REG_SRC2: next_src[2] = merge16(src[2], avs_writedata, avs_byteenable);
            `HAPC_REG_DST0: next_dst[0] = merge16(dst[0], avs_writedata, avs_byteenable);
            `HAPC_REG_DST1: next_dst[1] = merge16(dst[1], avs_writedata, avs_byteenable);
            `HAPC_REG_DST2: next_dst[2] = merge16(dst[2], avs_writedata, avs_byteenable);
            default: ;
         endcase
      end

      unique case (state)
         HAPC_IDLE: ;
         HAPC_CHECK: begin
            // everything is validated before the first byte lands, so a bad run writes nothing
            next_error_flag = chk_err;
            next_state = chk_err ? HAPC_IDLE : HAPC_CONV;
         end
         HAPC_CONV: begin
            if (op == HAPC_OP_HEX_TO_TEXT) begin
               // only the addressed byte is rewritten, its neighbour held
               if (cur_slot[0]) begin
                  next_dst[cur_slot[2:1]][15:8] = cur_char;
               end else begin
                  next_dst[cur_slot[2:1]][7:0] = cur_char;
               end
            end else begin
               next_dst[0][{cur_dig, 2'b00} +: 4] = to_digit(cur_src_byte);
            end
            if (idx == desig.cnt[1:0]) begin
               next_state = HAPC_IDLE;
            end else begin
               next_idx = idx + 2'b01;
            end
         end
         default: next_state = HAPC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= HAPC_IDLE;
         op <= HAPC_OP_HEX_TO_TEXT;
         desig <= `HAPC_WORD_RST;
         idx <= 2'b00;
         error_flag <= 1'b0;
         rd_ready <= 1'b0;
         avs_readdata <= `HAPC_RDATA_RST;
         for (int i = 0; i < NWORDS; i++) begin
            src[i] <= `HAPC_WORD_RST;
            dst[i] <= `HAPC_WORD_RST;
         end
      end else begin
         state <= next_state;
         op <= next_op;
         desig <= next_desig;
         idx <= next_idx;
         error_flag <= next_error_flag;
         rd_ready <= next_rd_ready;
         avs_readdata <= next_readdata;
         src <= next_src;
         dst <= next_dst;
      end
   end

   property p_ascii_code;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT) |->
            ((cur_char[6:0] >= `HAPC_ASC_ZERO && cur_char[6:0] <= `HAPC_ASC_NINE) ||
             (cur_char[6:0] >= `HAPC_ASC_A && cur_char[6:0] <= `HAPC_ASC_F));
   endproperty
   a_ascii_code: assert property (p_ascii_code) else $error("character code out of range");

   property p_par_none;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && desig.par == `HAPC_PAR_NONE) |-> !cur_char[7];
   endproperty
   a_par_none: assert property (p_par_none) else $error("parity bit set with no parity");

   property p_par_even;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && desig.par == `HAPC_PAR_EVEN) |-> !(^cur_char);
   endproperty
   a_par_even: assert property (p_par_even) else $error("character not even parity");

   property p_par_odd;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && desig.par == `HAPC_PAR_ODD) |-> (^cur_char);
   endproperty
   a_par_odd: assert property (p_par_odd) else $error("character not odd parity");

   property p_desig_err;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CHECK && desig_bad) |=> (error_flag && state == HAPC_IDLE);
   endproperty
   a_desig_err: assert property (p_desig_err) else $error("bad designator not flagged");

   property p_err_hold;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CHECK && chk_err && !avs_write) |=> (dst[0] == $past(dst[0]) &&
            dst[1] == $past(dst[1]) && dst[2] == $past(dst[2]));
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("destination changed on error");

   property p_err_clear;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CHECK && !chk_err) |=> (!error_flag && state == HAPC_CONV);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("flag not cleared on good run");

   property p_finish;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_IDLE && wr_acc && reg_idx == `HAPC_REG_CTRL && avs_byteenable[0]
          && avs_writedata[`HAPC_CTRL_START])
            |=> state == HAPC_CHECK ##[1:5] state == HAPC_IDLE;
   endproperty
   a_finish: assert property (p_finish) else $error("conversion did not finish in time");

   property p_slot_range;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV) |-> (cur_slot <= `HAPC_SLOT_LAST && idx <= desig.cnt[1:0]);
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("byte slot past last word");

   property p_stall;
      @(posedge core_clk) disable iff (rst)
         (avs_write && state != HAPC_IDLE) |-> (avs_waitrequest && !wr_acc);
   endproperty
   a_stall: assert property (p_stall) else $error("write taken while busy");

   property p_lower_first;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && cur_slot == `HAPC_SLOT_W0_LO)
            |=> dst[0][7:0] == $past(cur_char);
   endproperty
   a_lower_first: assert property (p_lower_first) else $error("lower byte not written");

   property p_upper_first;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && cur_slot == `HAPC_SLOT_W0_HI)
            |=> dst[0][15:8] == $past(cur_char);
   endproperty
   a_upper_first: assert property (p_upper_first) else $error("upper byte not written");

   property p_other_byte_hi;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && cur_slot == `HAPC_SLOT_W0_LO)
            |=> dst[0][15:8] == $past(dst[0][15:8]);
   endproperty
   a_other_byte_hi: assert property (p_other_byte_hi) else $error("neighbour upper byte changed");

   property p_other_byte_lo;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_HEX_TO_TEXT && cur_slot == `HAPC_SLOT_W0_HI)
            |=> dst[0][7:0] == $past(dst[0][7:0]);
   endproperty
   a_other_byte_lo: assert property (p_other_byte_lo) else $error("neighbour lower byte changed");

   property p_one_word;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_TEXT_TO_HEX)
            |=> (dst[1] == $past(dst[1]) && dst[2] == $past(dst[2]));
   endproperty
   a_one_word: assert property (p_one_word) else $error("digits written outside first word");

   property p_digit_keep;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CONV && op == HAPC_OP_TEXT_TO_HEX && cur_dig != `HAPC_DIG_0)
            |=> dst[0][3:0] == $past(dst[0][3:0]);
   endproperty
   a_digit_keep: assert property (p_digit_keep) else $error("unselected digit changed");

   property p_char_err;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_CHECK && op == HAPC_OP_TEXT_TO_HEX && !desig_bad && chk_err)
            |=> (error_flag && state == HAPC_IDLE);
   endproperty
   a_char_err: assert property (p_char_err) else $error("bad character not flagged");

   property p_idle_hold;
      @(posedge core_clk) disable iff (rst)
         (state == HAPC_IDLE && !wr_acc) |=> (dst[0] == $past(dst[0]) &&
            dst[1] == $past(dst[1]) && dst[2] == $past(dst[2]));
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("destination changed while idle");

   property p_flag_stable;
      @(posedge core_clk) disable iff (rst)
         (state != HAPC_CHECK) |=> error_flag == $past(error_flag);
   endproperty
   a_flag_stable: assert property (p_flag_stable) else $error("flag changed outside check");

endmodule : hapc_top

// File: tb/hapc_cpu_model.sv
`timescale 1ns/1ps
// controller side: issues register cycles, holds each until waitrequest is low
module hapc_cpu_model (
   input wire logic core_clk,
   output logic [5:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h0000_0000;
   end

   task automatic wr(input logic [3:0] idx, input logic [15:0] d);
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, d};
      avs_write <= 1'b1;
      @(posedge core_clk);
      while (avs_waitrequest) @(posedge core_clk);
      avs_write <= 1'b0;
      // released data inverted so stale values are never mistaken for live ones
      avs_writedata <= ~{16'h0000, d};
   endtask : wr

   task automatic rd(input logic [3:0] idx, output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= 1'b1;
      @(posedge core_clk);
      while (avs_waitrequest) @(posedge core_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd
endmodule : hapc_cpu_model

// File: tb/tb_hapc_top.sv
`timescale 1ns/1ps
`include "hapc_cfg.svh"
module tb_hapc_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic error_flag;
   logic busy;
   int err_total = 0;
   int num_checks = 0;
   logic [31:0] v;

   always #12.5 core_clk = ~core_clk;

   hapc_top u_hapc_top (
      .core_clk(core_clk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .error_flag(error_flag),
      .busy(busy)
   );

   hapc_cpu_model u_hapc_cpu_model (
      .core_clk(core_clk),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // preload, start, then a DST2 write that stalls for as long as the run is still busy
   task automatic run(input logic op, input logic [15:0] ds, input logic [15:0] s0, input logic [15:0] s1,
                      input logic [15:0] p0, input logic [15:0] p1, input logic [15:0] e0,
                      input logic [15:0] e1, input logic ee);
      logic [31:0] q;
      int n;
      u_hapc_cpu_model.wr(`HAPC_REG_DESIG, ds);
      u_hapc_cpu_model.wr(`HAPC_REG_SRC0, s0);
      u_hapc_cpu_model.wr(`HAPC_REG_SRC1, s1);
      u_hapc_cpu_model.wr(`HAPC_REG_DST0, p0);
      u_hapc_cpu_model.wr(`HAPC_REG_DST1, p1);
      u_hapc_cpu_model.wr(`HAPC_REG_CTRL, {14'h0000, op, 1'b1});
      // looked at mid-cycle, where the state register has settled
      @(negedge core_clk);
      chk("busy_run", {31'h0000_0000, busy}, 32'h0000_0001);
      u_hapc_cpu_model.wr(`HAPC_REG_DST2, 16'h5A5A);
      n = 0;
      q = 32'h0000_0001;
      while (q[0] && n < 20) begin
         u_hapc_cpu_model.rd(`HAPC_REG_STATUS, q);
         n++;
      end
      chk("status", q, {30'h0000_0000, ee, 1'b0});
      chk("error_flag", {31'h0000_0000, error_flag}, {31'h0000_0000, ee});
      chk("busy_idle", {31'h0000_0000, busy}, 32'h0000_0000);
      u_hapc_cpu_model.rd(`HAPC_REG_DST0, q);
      chk("dst0", q, {16'h0000, e0});
      u_hapc_cpu_model.rd(`HAPC_REG_DST1, q);
      chk("dst1", q, {16'h0000, e1});
      u_hapc_cpu_model.rd(`HAPC_REG_DST2, q);
      chk("dst2", q, 32'h0000_5A5A);
   endtask : run

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      u_hapc_cpu_model.rd(`HAPC_REG_STATUS, v);
      chk("status_rst", v, 32'h0000_0000);
      u_hapc_cpu_model.rd(`HAPC_REG_DESIG, v);
      chk("desig_rst", v, 32'h0000_0000);
      u_hapc_cpu_model.rd(4'hC, v);
      chk("unmapped", v, 32'h0000_0000);
      u_hapc_cpu_model.wr(`HAPC_REG_STATUS, 16'hFFFF);
      u_hapc_cpu_model.rd(`HAPC_REG_STATUS, v);
      chk("status_ro", v, 32'h0000_0000);
      run(1'b0, 16'h0121, 16'h1234, 16'h0000, 16'hAAAA, 16'hBBBB, 16'h33AA, 16'h3132, 1'b0);
      run(1'b0, 16'h1030, 16'hA961, 16'h0000, 16'h0000, 16'h0000, 16'h36B1, 16'h4139, 1'b0);
      run(1'b0, 16'h2030, 16'hA961, 16'h0000, 16'h0000, 16'h0000, 16'hB631, 16'hC1B9, 1'b0);
      run(1'b0, 16'h0013, 16'hA961, 16'h0000, 16'hAAAA, 16'hBBBB, 16'h3141, 16'hBBBB, 1'b0);
      run(1'b0, 16'h3000, 16'h1234, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b0, 16'h0200, 16'h1234, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b0, 16'h0040, 16'h1234, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b0, 16'h0004, 16'h1234, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h1011, 16'h36B1, 16'h0000, 16'hFFFF, 16'hBBBB, 16'hF61F, 16'hBBBB, 1'b0);
      run(1'b1, 16'h0123, 16'h4600, 16'h3930, 16'h1234, 16'hBBBB, 16'hF290, 16'hBBBB, 1'b0);
      run(1'b1, 16'h0000, 16'h00B1, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h1000, 16'h0031, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h2000, 16'h0036, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h0000, 16'h0047, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h0000, 16'h003A, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h5000, 16'h0031, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAAA, 16'hBBBB, 1'b1);
      run(1'b1, 16'h2000, 16'h0031, 16'h0000, 16'hAAAA, 16'hBBBB, 16'hAAA1, 16'hBBBB, 1'b0);
      end_sim;
   end

   // about 500 cycles expected; generous margin
   initial begin
      repeat (8000) @(posedge core_clk);
      err_total++;
      end_sim;
   end
endmodule : tb_hapc_top
